// [src/ebc_break_ctrl.sv]
// ebc_break_ctrl: run/break/step control with two masked opcode comparators
// assumes core status arrives on ref_clk; sync_trigger_input is asynchronous
`timescale 1ns/1ps
module ebc_break_ctrl
	import ebc_pkg::*;
#(
	parameter int TIMER_WIDTH = TMR_W
) (
	input wire logic ref_clk, // 100 MHz clock
	input wire logic nrst, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire ebc_core_s coreIn, // core fetch/boundary status
	output ebc_ctl_s coreCtl, // core control
	input wire logic sync_trigger_input, // external sync break input
	output logic sync_pulse_output // sync output pulse
);
	typedef struct packed {
		logic awHave;
		logic [7:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		ebc_mode_e mode;
		logic [ADDR_W-1:0] pcLoad;
		logic loadPc;
		logic [ADDR_W-1:0] bp0Val;
		logic [ADDR_W-1:0] bp0Mask;
		logic [ADDR_W-1:0] bp1Val;
		logic [ADDR_W-1:0] bp1Mask;
		logic bp0En;
		logic bp1En;
		logic bp1Cfg;
		logic syncOutEn;
		logic syncInBrk;
		logic xtalSel;
		logic [7:0] trcQual;
		logic abortPend;
		logic brkPend;
		logic [TIMER_WIDTH-1:0] timer;
		logic [ADDR_W-1:0] haltPc;
		logic [3:0] pulseCnt;
		logic [1:0] stepTicks;
		logic tick;
		logic syncA;
		logic syncB;
	} ebc_state_s;

	ebc_state_s st_r;
	ebc_state_s st_nxt;
	logic wrFire;
	logic rdFire;
	logic [31:0] wd;
	logic [31:0] rd;
	logic hit0;
	logic hit1;
	logic brkHit;
	logic running;

	ebc_bp_cmp #(
		.WIDTH(ADDR_W)
	) cmp0_u (
		.armed(st_r.bp0En),
		.fetchValid(coreIn.fetchValid),
		.opcodeFetch(coreIn.opcodeFetch),
		.fetchAddr(coreIn.fetchAddr),
		.matchVal(st_r.bp0Val),
		.dontCare(st_r.bp0Mask),
		.hit(hit0)
	);
	ebc_bp_cmp #(
		.WIDTH(ADDR_W)
	) cmp1_u (
		.armed(st_r.bp1En),
		.fetchValid(coreIn.fetchValid),
		.opcodeFetch(coreIn.opcodeFetch),
		.fetchAddr(coreIn.fetchAddr),
		.matchVal(st_r.bp1Val),
		.dontCare(st_r.bp1Mask),
		.hit(hit1)
	);
	assign brkHit = hit0 | hit1;
	assign running = (st_r.mode != HALTED);

	assign s_axi_awready = ~st_r.awHave & ~st_r.bValid;
	assign s_axi_wready = ~st_r.wHave & ~st_r.bValid;
	assign s_axi_arready = ~st_r.rValid;
	assign s_axi_bvalid = st_r.bValid;
	assign s_axi_bresp = st_r.bResp;
	assign s_axi_rvalid = st_r.rValid;
	assign s_axi_rdata = st_r.rData;
	assign s_axi_rresp = st_r.rResp;
	assign sync_pulse_output = (st_r.pulseCnt != 4'h0);
	assign wrFire = st_r.awHave & st_r.wHave & ~st_r.bValid;
	assign rdFire = s_axi_arvalid & ~st_r.rValid;
	assign wd = st_r.wData;

	always_comb begin
		unique case (s_axi_araddr)
			OFF_CTRL: rd = {
				20'h0_0000,
				st_r.xtalSel,
				st_r.syncInBrk,
				st_r.syncOutEn,
				st_r.bp1Cfg,
				8'h00
			};
			OFF_STATUS: rd = {
				24'h00_0000,
				2'h0,
				st_r.abortPend,
				st_r.bp1En,
				st_r.bp0En,
				1'h0,
				st_r.mode
			};
			OFF_PCLOAD: rd = {16'h0000, st_r.pcLoad};
			OFF_BP0: rd = {st_r.bp0Mask, st_r.bp0Val};
			OFF_BP1: rd = {st_r.bp1Mask, st_r.bp1Val};
			OFF_TIMER: rd = 32'(st_r.timer);
			OFF_HALTPC: rd = {16'h0000, st_r.haltPc};
			OFF_TRCQUAL: rd = {24'h00_0000, st_r.trcQual};
			default: rd = 32'h0000_0000;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.loadPc = 1'b0;
		st_nxt.tick = 1'b0;
		st_nxt.syncA = sync_trigger_input;
		st_nxt.syncB = st_r.syncA;
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.awHave = 1'b1;
			st_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.wHave = 1'b1;
			st_nxt.wData = s_axi_wdata;
			st_nxt.wStrb = s_axi_wstrb;
		end
		if (st_r.bValid && s_axi_bready) begin
			st_nxt.bValid = 1'b0;
		end
		if (st_r.rValid && s_axi_rready) begin
			st_nxt.rValid = 1'b0;
		end
		if (rdFire) begin
			st_nxt.rValid = 1'b1;
			st_nxt.rData = rd;
			st_nxt.rResp = 2'h0;
		end
		if (st_r.pulseCnt != 4'h0) begin
			st_nxt.pulseCnt = st_r.pulseCnt - 4'h1;
		end
		if (st_r.stepTicks != 2'h0) begin
			st_nxt.stepTicks = st_r.stepTicks - 2'h1;
			st_nxt.tick = 1'b1;
		end
		if (st_r.mode == RUNNING) begin
			st_nxt.timer = st_r.timer + 1'b1;
		end
		// sync input only in real time
		if (st_r.mode == RUNNING && st_r.syncInBrk && st_r.syncB) begin
			st_nxt.brkPend = 1'b1;
		end
		if (running && brkHit) begin
			st_nxt.brkPend = 1'b1;
		end
		if (running && coreIn.instrDone) begin
			st_nxt.haltPc = coreIn.nextPc;
			if (st_r.mode == STEPPING || st_r.brkPend || brkHit || st_r.abortPend) begin
				st_nxt.mode = HALTED;
				st_nxt.brkPend = 1'b0;
				st_nxt.abortPend = 1'b0;
			end
		end
		if (wrFire) begin
			st_nxt.awHave = 1'b0;
			st_nxt.wHave = 1'b0;
			st_nxt.bValid = 1'b1;
			st_nxt.bResp = 2'h0;
			unique case (st_r.awAddr)
				OFF_CTRL: begin
					if (st_r.wStrb[1]) begin
						st_nxt.bp1Cfg = wd[CFG_BP1EN];
						st_nxt.syncOutEn = wd[CFG_SYNCOUTEN];
						st_nxt.syncInBrk = wd[CFG_SYNCINBRK];
						st_nxt.xtalSel = wd[CFG_XTALSEL];
					end
					if (st_r.wStrb[0]) begin
						if (wd[CMD_LOADPC] && !running) begin
							st_nxt.loadPc = 1'b1;
						end
						if (wd[CMD_ABORT] && running) begin
							st_nxt.abortPend = 1'b1;
						end
						if (wd[CMD_FOREVER]) begin
							st_nxt.bp0En = 1'b0;
							st_nxt.bp1En = 1'b0;
						end
						if (wd[CMD_SETBP]) begin
							st_nxt.bp0En = 1'b1;
							st_nxt.bp1En = st_nxt.bp1Cfg;
						end
						if (wd[CMD_GO] && !running && !wd[CMD_LOADPC]) begin
							st_nxt.mode = RUNNING;
							st_nxt.timer = TIMER_WIDTH'(TIMER_RST);
							st_nxt.abortPend = 1'b0;
							st_nxt.brkPend = 1'b0;
						end else if (wd[CMD_STEP] && !running && !wd[CMD_LOADPC]) begin
							st_nxt.mode = STEPPING;
							st_nxt.timer = TIMER_WIDTH'(TIMER_RST);
							st_nxt.abortPend = 1'b0;
							st_nxt.brkPend = 1'b0;
							st_nxt.stepTicks = STEP_TMR_TICKS;
							if (st_nxt.syncOutEn) begin
								st_nxt.pulseCnt = SYNC_PULSE_CYC;
							end
						end
					end
				end
				OFF_PCLOAD: begin
					if (!running) begin
						st_nxt.pcLoad = wd[ADDR_W-1:0];
					end
				end
				OFF_BP0: begin
					if (!running) begin
						st_nxt.bp0Val = wd[15:0];
						st_nxt.bp0Mask = wd[31:16];
						st_nxt.bp0En = 1'b0;
						st_nxt.bp1En = 1'b0;
					end
				end
				OFF_BP1: begin
					if (!running) begin
						st_nxt.bp1Val = wd[15:0];
						st_nxt.bp1Mask = wd[31:16];
						st_nxt.bp0En = 1'b0;
						st_nxt.bp1En = 1'b0;
					end
				end
				OFF_TRCQUAL: begin
					st_nxt.trcQual = wd[7:0];
				end
				default: begin
					st_nxt.bResp = 2'h2;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.mode <= HALTED;
			st_r.timer <= TIMER_WIDTH'(TIMER_RST);
			st_r.pcLoad <= PC_RST;
			st_r.haltPc <= PC_RST;
			st_r.xtalSel <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		coreCtl.run = running;
		coreCtl.loadPc = st_r.loadPc;
		coreCtl.pcValue = st_r.pcLoad;
		coreCtl.timerTick = st_r.tick;
		coreCtl.xtalSel = st_r.xtalSel;
		coreCtl.traceEn = (st_r.mode == STEPPING)
			| ((st_r.mode == RUNNING) & (st_r.trcQual == 8'h00 | coreIn.trcCond));
	end
endmodule : ebc_break_ctrl

// one opcode-fetch comparator with a per-bit don't-care mask
module ebc_bp_cmp
	import ebc_pkg::*;
#(
	parameter int WIDTH = ADDR_W
) (
	input wire logic armed, // comparator armed
	input wire logic fetchValid, // fetch this cycle
	input wire logic opcodeFetch, // first byte of an instruction
	input wire logic [WIDTH-1:0] fetchAddr, // fetch address
	input wire logic [WIDTH-1:0] matchVal, // breakpoint value
	input wire logic [WIDTH-1:0] dontCare, // 1 = bit ignored
	output logic hit // opcode fetch matched
);
	logic opFetch;
	logic [WIDTH-1:0] diffBits;
	logic [WIDTH-1:0] caredDiff;

	assign opFetch = fetchValid & opcodeFetch;
	assign diffBits = fetchAddr ^ matchVal;
	assign caredDiff = diffBits & ~dontCare;
	assign hit = armed & opFetch & (caredDiff == '0);
endmodule : ebc_bp_cmp

// [src/ebc_pkg.sv]
// ebc_pkg: shared constants and carriers for the emulation break controller
// assumes a single 100 MHz ref_clk domain and an AXI4-Lite register port
package ebc_pkg;
	localparam int ADDR_W = 16;
	localparam int TMR_W = 32;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_PCLOAD = 8'h08;
	localparam logic [7:0] OFF_BP0 = 8'h0C;
	localparam logic [7:0] OFF_BP1 = 8'h10;
	localparam logic [7:0] OFF_TIMER = 8'h14;
	localparam logic [7:0] OFF_HALTPC = 8'h18;
	localparam logic [7:0] OFF_TRCQUAL = 8'h1C;
	// command bits in CTRL (write 1 to act), then CTRL config bits (stored as written)
	localparam int CMD_LOADPC = 0;
	localparam int CMD_GO = 1;
	localparam int CMD_STEP = 2;
	localparam int CMD_ABORT = 3;
	localparam int CMD_FOREVER = 4;
	localparam int CMD_SETBP = 5;
	localparam int CFG_BP1EN = 8;
	localparam int CFG_SYNCOUTEN = 9;
	localparam int CFG_SYNCINBRK = 10;
	localparam int CFG_XTALSEL = 11;
	// clock, pulse, timer and reset figures
	localparam int XTAL_KHZ = 12000;
	localparam int REF_KHZ = 100000;
	localparam int SYNC_PULSE_NS = 40;
	localparam int CLK_NS = 10;
	localparam logic [3:0] SYNC_PULSE_CYC = 4'((SYNC_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [1:0] STEP_TMR_TICKS = 2'h2;
	localparam logic [TMR_W-1:0] TIMER_RST = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] PC_RST = 16'h0000;

	typedef enum logic [1:0] {
		HALTED,
		RUNNING,
		STEPPING
	} ebc_mode_e;

	// status of the emulated core, from same clock domain
	typedef struct packed {
		logic fetchValid;
		logic opcodeFetch;
		logic [ADDR_W-1:0] fetchAddr;
		logic instrDone;
		logic [ADDR_W-1:0] nextPc;
		logic trcCond;
	} ebc_core_s;

	// control to the emulated core
	typedef struct packed {
		logic run;
		logic loadPc;
		logic [ADDR_W-1:0] pcValue;
		logic timerTick;
		logic traceEn;
		logic xtalSel;
	} ebc_ctl_s;
endpackage : ebc_pkg

// [testbench/ebc_break_ctrl_asserts.sv]
// ebc_break_ctrl_asserts: port checks bound into ebc_break_ctrl
// assumes one ref_clk domain and synchronous active-low nrst
`timescale 1ns/1ps
module ebc_break_ctrl_asserts
	import ebc_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic nrst, // reset
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic s_axi_rvalid, // r valid
	input wire ebc_core_s coreIn, // core status
	input wire ebc_ctl_s coreCtl, // core control
	input wire logic sync_pulse_output // sync out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_loadHalted;
		coreCtl.loadPc |-> !coreCtl.run;
	endproperty
	a_loadHalted: assert property (p_loadHalted) else $error("pc load while running");
	property p_runHold;
		coreCtl.run && !coreIn.instrDone |=> coreCtl.run;
	endproperty
	a_runHold: assert property (p_runHold) else $error("halt off a boundary");
	property p_xtalRst;
		$rose(nrst) |-> coreCtl.xtalSel;
	endproperty
	a_xtalRst: assert property (p_xtalRst) else $error("clock select wrong after reset");
	property p_syncWidth;
		$rose(sync_pulse_output) |-> sync_pulse_output[*4] ##1 !sync_pulse_output;
	endproperty
	a_syncWidth: assert property (p_syncWidth) else $error("sync pulse width wrong");
	property p_bLat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_bLat: assert property (p_bLat) else $error("write response late");
	property p_rLat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rLat: assert property (p_rLat) else $error("read data late");
	property p_bBlock;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_bBlock: assert property (p_bBlock) else $error("write taken with response pending");
	property p_rBlock;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rBlock: assert property (p_rBlock) else $error("read taken with data pending");
	c_sync: cover property ($rose(sync_pulse_output));
	c_halt: cover property ($fell(coreCtl.run));
	c_load: cover property (coreCtl.loadPc);
endmodule : ebc_break_ctrl_asserts
bind ebc_break_ctrl ebc_break_ctrl_asserts chk_u (.*);

// [testbench/ebc_core_model.sv]
// ebc_core_model: emulated core, three-cycle instructions of two bytes
// assumes coreCtl from ebc_break_ctrl on the same ref_clk
`timescale 1ns/1ps
module ebc_core_model
	import ebc_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire ebc_ctl_s ctl, // control in
	output ebc_core_s core // status out
);
	logic [15:0] pc = 16'h0000;
	logic [1:0] ph = 2'h0;
	always @(posedge ref_clk) begin
		if (ctl.loadPc) begin
			pc <= ctl.pcValue;
		end else if (ctl.run && ph == 2'h2) begin
			pc <= pc + 16'h0002;
		end
		ph <= (ctl.run && ph != 2'h2) ? ph + 2'h1 : 2'h0;
	end
	// opcode at pc, operand at pc+1, boundary on third cycle
	always_comb begin
		core.fetchValid = ctl.run && ph != 2'h2;
		core.opcodeFetch = ctl.run && ph == 2'h0;
		core.fetchAddr = core.fetchValid ? pc + {15'h0000, ph[0]} : ~pc;
		core.instrDone = ctl.run && ph == 2'h2;
		core.nextPc = core.instrDone ? pc + 16'h0002 : ~pc;
		core.trcCond = ph[0];
	end
endmodule : ebc_core_model

// [testbench/tb_ebc_break_ctrl.sv]
// tb_ebc_break_ctrl: register-level tests of run, step and breakpoints
// assumes ebc_core_model as the core; bready and rready held high
`timescale 1ns/1ps
module tb_ebc_break_ctrl
	import ebc_pkg::*;
;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] awA = 8'h00;
	logic [7:0] arA = 8'h00;
	logic [31:0] wD = 32'h0;
	logic awV = 1'b0;
	logic wV = 1'b0;
	logic arV = 1'b0;
	logic awR, wR, bV, arR, rV, sync;
	logic [1:0] bResp;
	logic [1:0] lastB;
	logic [31:0] rD, v;
	logic syncQ = 1'b0;
	logic syncIn = 1'b0;
	logic [1:0] rResp;
	logic [1:0] lastR;
	ebc_core_s core;
	ebc_ctl_s ctl;
	int fail_count = 0;
	int tests_run = 0;
	int nIns = 0, nTick = 0, nSync = 0, noTrc = 0, cyc = 0;
	int iB = 0, tB = 0, sB = 0, trB = 0;
	ebc_break_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
		.s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wR),
		.s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(1'b1), .s_axi_araddr(arA), .s_axi_arvalid(arV),
		.s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(1'b1),
		.coreIn(core), .coreCtl(ctl), .sync_trigger_input(syncIn), .sync_pulse_output(sync));
	ebc_core_model core_u (.ref_clk(ref_clk), .ctl(ctl), .core(core));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		syncQ <= sync;
		if (core.instrDone === 1'b1) nIns <= nIns + 1;
		if (ctl.timerTick === 1'b1) nTick <= nTick + 1;
		if (sync === 1'b1 && syncQ !== 1'b1) nSync <= nSync + 1;
		if (ctl.run === 1'b1 && ctl.traceEn !== 1'b1) noTrc <= noTrc + 1;
	end
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awA <= a;
		wD <= d;
		awV <= 1'b1;
		wV <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awR) awV <= 1'b0;
			if (wR) wV <= 1'b0;
		end while ((awV && !awR) || (wV && !wR));
		do @(posedge ref_clk); while (bV !== 1'b1);
		lastB = bResp;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		arA <= a;
		arV <= 1'b1;
		do @(posedge ref_clk); while (arR !== 1'b1);
		arV <= 1'b0;
		do @(posedge ref_clk); while (rV !== 1'b1);
		d = rD;
		lastR = rResp;
	endtask : axr
	task automatic waitHalt();
		logic [31:0] s;
		do axr(OFF_STATUS, s); while (s[1:0] !== 2'h0);
	endtask : waitHalt
	task automatic clr();
		iB = nIns;
		tB = nTick;
		sB = nSync;
		trB = noTrc;
	endtask : clr
	task automatic loadPc(input logic [31:0] a);
		axw(OFF_PCLOAD, a);
		axw(OFF_CTRL, 32'h1 << CMD_LOADPC);
		clr();
	endtask : loadPc
	initial begin
		fork
			begin
				repeat (2) @(posedge ref_clk);
				nrst <= 1'b1;
				@(posedge ref_clk);
				chk(ctl.xtalSel, 32'h1);
				axr(OFF_STATUS, v);
				chk(v, 32'h0);
				axr(8'h40, v);
				chk(v, 32'h0);
				chk(lastR, 32'h0);
				axw(8'h40, 32'h5);
				chk(lastB, 32'h2);
				$display("test reset done");
				axw(OFF_TRCQUAL, 32'hFF);
				loadPc(32'h200);
				axw(OFF_CTRL, (32'h1 << CMD_GO) | (32'h1 << CMD_FOREVER));
				axr(OFF_STATUS, v);
				chk(v, 32'h1);
				while (nIns - iB < 5) @(posedge ref_clk);
				axw(OFF_CTRL, 32'h1 << CMD_ABORT);
				waitHalt();
				axr(OFF_HALTPC, v);
				chk(v, 32'h200 + 32'(2 * (nIns - iB)));
				axr(OFF_TIMER, v);
				chk(32'(v != 32'h0), 32'h1);
				chk(32'(noTrc - trB != 0), 32'h1);
				$display("test run done");
				loadPc(32'h100);
				syncIn <= 1'b1;
				axw(OFF_CTRL, (32'h1 << CMD_STEP) | (32'h1 << CFG_SYNCOUTEN) | (32'h1 << CFG_SYNCINBRK));
				waitHalt();
				axr(OFF_HALTPC, v);
				chk(v, 32'h102);
				axr(OFF_TIMER, v);
				chk(v, 32'h0);
				chk(nIns - iB, 32'h1);
				chk(nTick - tB, 32'h2);
				chk(nSync - sB, 32'h1);
				chk(noTrc - trB, 32'h0);
				chk(ctl.xtalSel, 32'h0);
				$display("test step done");
				axw(OFF_BP0, 32'h0000_0109);
				axw(OFF_BP1, 32'h000F_0110);
				axw(OFF_CTRL, (32'h1 << CMD_SETBP) | (32'h1 << CFG_BP1EN));
				axr(OFF_STATUS, v);
				chk(v, 32'h18);
				clr();
				axw(OFF_CTRL, 32'h1 << CMD_GO);
				waitHalt();
				axr(OFF_HALTPC, v);
				chk(v, 32'h112);
				chk(nIns - iB, 32'h8);
				clr();
				axw(OFF_CTRL, 32'h1 << CMD_GO);
				waitHalt();
				axr(OFF_HALTPC, v);
				chk(v, 32'h114);
				chk(nIns - iB, 32'h1);
				axw(OFF_BP0, 32'h0000_0200);
				axr(OFF_STATUS, v);
				chk(v, 32'h0);
				$display("test break done");
				clr();
				axw(OFF_CTRL, (32'h1 << CMD_GO) | (32'h1 << CFG_SYNCINBRK));
				waitHalt();
				axr(OFF_HALTPC, v);
				chk(v, 32'h116);
				chk(nIns - iB, 32'h1);
				syncIn <= 1'b0;
				axw(OFF_CTRL, 32'h1 << CMD_STEP);
				waitHalt();
				axr(OFF_HALTPC, v);
				chk(v, 32'h118);
				chk(nSync - sB, 32'h0);
				$display("test sync done");
			end
			begin
				wait (cyc == 20000);
				fail_count++;
			end
		join_any
		tally_and_finish();
	end
endmodule : tb_ebc_break_ctrl
